// ---- logic/tmr_pkg.sv ----
// Shared constants for the three-lane serial pixel receiver
package tmr_pkg;
   // --------------------------------------------------------------
   // Link geometry
   // --------------------------------------------------------------
   localparam int LANES          = 3;
   localparam int SYM_BITS       = 10;
   localparam int PIX_BITS       = 8;
   localparam int OVERSAMPLE     = 4;
   localparam int PIXEL_CYCLES   = SYM_BITS * OVERSAMPLE;
   localparam int OUT_PIXELS_2X  = 2;
   localparam int STAGGER_NUM    = 1;
   localparam int STAGGER_DEN    = 4;
   localparam int STAGGER_CYCLES = (OUT_PIXELS_2X * PIXEL_CYCLES * STAGGER_NUM) / STAGGER_DEN;
   localparam int TIMER_W        = 8;
   localparam logic [3:0] SYM_LAST = 4'h9;

   // --------------------------------------------------------------
   // Link activity timing, in pixel clock periods
   // --------------------------------------------------------------
   localparam int ACTIVE_WINDOW_PERIODS = 1600;
   localparam int INACTIVE_PERIODS_DEF  = 1000000;

   // --------------------------------------------------------------
   // Control characters, serial order LSB first
   // --------------------------------------------------------------
   localparam logic [9:0] TOKEN_C00 = 10'h354;
   localparam logic [9:0] TOKEN_C01 = 10'h0ab;
   localparam logic [9:0] TOKEN_C10 = 10'h154;
   localparam logic [9:0] TOKEN_C11 = 10'h2ab;

   // --------------------------------------------------------------
   // Pin synchroniser slots and reset values
   // --------------------------------------------------------------
   localparam int IN_BLUE  = 0;
   localparam int IN_GREEN = 1;
   localparam int IN_RED   = 2;
   localparam int IN_LCLK  = 3;
   localparam int IN_PD    = 4;
   localparam int IN_PDO   = 5;
   localparam int IN_PIXS  = 6;
   localparam int IN_OFFSET_OUTPUT_SELECT_N  = 7;
   localparam int IN_COUNT = 8;
   localparam logic [7:0] PIN_RST = 8'hb0;

   // --------------------------------------------------------------
   // Register map (byte addresses) and fields
   // --------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int CTRL_RELOCK      = 0;
   localparam int STAT_ACTIVE      = 0;
   localparam int STAT_DE          = 1;
   localparam int STAT_ALIGNED_LSB = 4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage

// ---- logic/tmr_receiver.sv ----
// Three-lane serial pixel receiver: oversampling, alignment, decode, output
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps

module tmr_receiver
   import tmr_pkg::*;
#(
   parameter int INACTIVE_PERIODS = INACTIVE_PERIODS_DEF
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        blue_lane,
   input  wire logic        green_lane,
   input  wire logic        red_lane,
   input  wire logic        link_clock,
   input  wire logic        full_power_down_n,
   input  wire logic        output_driver_off_n,
   input  wire logic        two_pixel_mode,
   input  wire logic        offset_output_select_n,
   output logic      [23:0] even_pixel_bus,
   output logic      [23:0] odd_pixel_bus,
   output logic             display_enable,
   output logic             hsync,
   output logic             vsync,
   output logic      [3:1]  user_control_bits,
   output logic             output_pixel_clock,
   output logic             link_active_flag,
   output logic             data_oe,
   output logic             keep_alive_oe
);

   localparam int CNT_W = $clog2(INACTIVE_PERIODS + 1);

   if (INACTIVE_PERIODS <= ACTIVE_WINDOW_PERIODS || OVERSAMPLE != 4)
   begin : g_bad_param
      $error("tmr_receiver: unsupported parameter values");
   end

   // --------------------------------------------------------------
   // Character helpers
   // --------------------------------------------------------------
   // Returns {is_control, c1, c0}
   function automatic logic [2:0] ctl_class(input logic [9:0] q);
      logic [2:0] r;
      r = 3'h0;
      if (q == TOKEN_C00) r = 3'h4;
      if (q == TOKEN_C01) r = 3'h5;
      if (q == TOKEN_C10) r = 3'h6;
      if (q == TOKEN_C11) r = 3'h7;
      return r;
   endfunction

   function automatic logic [7:0] tmds_decode(input logic [9:0] q);
      logic [7:0] d;
      logic [7:0] r;
      d = q[9] ? ~q[7:0] : q[7:0];
      r[0] = d[0];
      for (int i = 1; i < PIX_BITS; i++)
         r[i] = q[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
      return r;
   endfunction

   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   logic [IN_COUNT-1:0] pin_raw;
   logic [IN_COUNT-1:0] s1;
   logic [IN_COUNT-1:0] s2;
   logic [IN_COUNT-1:0] s3;
   logic [IN_COUNT-1:0] pin;
   logic [IN_COUNT-1:0] next_pin;

   assign pin_raw = {offset_output_select_n, two_pixel_mode, output_driver_off_n,
                     full_power_down_n, link_clock, red_lane, green_lane, blue_lane};

   // A change is taken only once the second and third stages agree
   always_comb
   begin
      next_pin = (s2 & s3) | (pin & (s2 | s3));
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1  <= PIN_RST;
         s2  <= PIN_RST;
         s3  <= PIN_RST;
         pin <= PIN_RST;
      end
      else
      begin
         s1  <= pin_raw;
         s2  <= s1;
         s3  <= s2;
         pin <= next_pin;
      end
   end

   // --------------------------------------------------------------
   // Register bus slave
   // --------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic        wr_pend;
   logic        next_wr_pend;
   logic [7:0]  wr_addr;
   logic [7:0]  next_wr_addr;
   logic [31:0] next_hrdata;
   logic [LANES-1:0] aligned;

   always_comb
   begin
      next_ctrl    = ctrl;
      next_wr_pend = 1'b0;
      next_wr_addr = wr_addr;
      next_hrdata  = hrdata;
      next_ctrl[CTRL_RELOCK] = 1'b0;
      if (wr_pend && wr_addr == REG_CTRL)
         next_ctrl = hwdata;
      if (hsel && hready && htrans[1])
      begin
         next_wr_pend = hwrite;
         next_wr_addr = haddr[7:0];
         next_hrdata  = 32'h0;
         if (!hwrite && haddr[7:0] == REG_CTRL)
            next_hrdata = ctrl;
         else if (!hwrite && haddr[7:0] == REG_STATUS)
         begin
            next_hrdata[STAT_ACTIVE] = link_active_flag;
            next_hrdata[STAT_DE]     = display_enable;
            next_hrdata[STAT_ALIGNED_LSB +: LANES] = aligned;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl      <= CTRL_RST;
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hrdata    <= 32'h0;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         ctrl      <= next_ctrl;
         wr_pend   <= next_wr_pend;
         wr_addr   <= next_wr_addr;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // Per-lane bit phase and character lock
   // --------------------------------------------------------------
   logic [1:0]       ph      [LANES];
   logic [1:0]       sel     [LANES];
   logic             prev    [LANES];
   logic [9:0]       sr      [LANES];
   logic [3:0]       bcnt    [LANES];
   logic [9:0]       sym     [LANES];
   logic [LANES-1:0] sym_vld;

   for (genvar l = 0; l < LANES; l++)
   begin : g_lane
      logic [1:0] next_ph;
      logic [1:0] next_sel;
      logic       next_prev;
      logic [9:0] next_sr;
      logic [3:0] next_bcnt;
      logic [9:0] next_sym;
      logic       next_vld;
      logic       next_aligned;
      logic       hunting;
      logic       bit_in;

      always_comb
      begin
         bit_in       = pin[IN_BLUE + l];
         hunting      = !aligned[l] || (!link_active_flag && !display_enable);
         next_ph      = ph[l] + 2'h1;
         next_prev    = bit_in;
         next_sel     = sel[l];
         next_sr      = sr[l];
         next_bcnt    = bcnt[l];
         next_sym     = sym[l];
         next_vld     = 1'b0;
         next_aligned = aligned[l];
         // Centre the sample two phases after the last edge seen
         if (hunting && bit_in != prev[l])
            next_sel = ph[l] + 2'h2;
         if (ph[l] == sel[l])
         begin
            next_sr   = {bit_in, sr[l][9:1]};
            next_bcnt = (bcnt[l] == SYM_LAST) ? 4'h0 : bcnt[l] + 4'h1;
            next_vld  = (bcnt[l] == SYM_LAST) && aligned[l];
            // Blanking tokens are long enough to lock on
            if (hunting && ctl_class(next_sr) != 3'h0)
            begin
               next_bcnt    = 4'h0;
               next_vld     = 1'b1;
               next_aligned = 1'b1;
            end
            next_sym = next_sr;
         end
         if (!pin[IN_PD] || ctrl[CTRL_RELOCK])
         begin
            next_aligned = 1'b0;
            next_vld     = 1'b0;
         end
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            ph[l]      <= 2'h0;
            sel[l]     <= 2'h2;
            prev[l]    <= 1'b0;
            sr[l]      <= 10'h000;
            bcnt[l]    <= 4'h0;
            sym[l]     <= 10'h000;
            sym_vld[l] <= 1'b0;
            aligned[l] <= 1'b0;
         end
         else
         begin
            ph[l]      <= next_ph;
            sel[l]     <= next_sel;
            prev[l]    <= next_prev;
            sr[l]      <= next_sr;
            bcnt[l]    <= next_bcnt;
            sym[l]     <= next_sym;
            sym_vld[l] <= next_vld;
            aligned[l] <= next_aligned;
         end
      end
   end

   // --------------------------------------------------------------
   // Deskew, decode and output staging
   // --------------------------------------------------------------
   logic [LANES-1:0] pend_vld;
   logic [LANES-1:0] next_pend_vld;
   logic [9:0]       pend    [LANES];
   logic [9:0]       next_pend [LANES];
   logic [9:0]       cur     [LANES];
   logic [2:0]       cls     [LANES];
   logic             fire;
   logic             present;
   logic             de_toggle;
   logic             new_de;
   logic [23:0]      pix;
   logic             odd_slot;
   logic             next_odd_slot;
   logic [23:0]      even_hold;
   logic [23:0]      next_even_hold;
   logic [TIMER_W-1:0] offset_output_select_n_cnt;
   logic [TIMER_W-1:0] next_offset_output_select_n_cnt;
   logic [TIMER_W-1:0] ock_cnt;
   logic [TIMER_W-1:0] next_ock_cnt;
   logic [23:0]      next_even;
   logic [23:0]      next_odd;
   logic             next_de;
   logic             next_hsync;
   logic             next_vsync;
   logic [3:1]       next_ctl;
   logic             next_ock;
   logic             next_data_oe;
   logic             next_keep_oe;

   always_comb
   begin
      // A lane arriving early waits here for the others
      for (int l = 0; l < LANES; l++)
      begin
         cur[l]           = sym_vld[l] ? sym[l] : pend[l];
         cls[l]           = ctl_class(cur[l]);
         next_pend[l]     = cur[l];
      end
      fire          = &(sym_vld | pend_vld);
      next_pend_vld = fire ? '0 : (sym_vld | pend_vld);
      new_de        = !(cls[0][2] || cls[1][2] || cls[2][2]);
      pix           = {tmds_decode(cur[2]), tmds_decode(cur[1]), tmds_decode(cur[0])};
      present       = fire && (!pin[IN_PIXS] || odd_slot);
      de_toggle     = present && new_de != display_enable;
      next_odd_slot = fire ? (pin[IN_PIXS] && !odd_slot) : odd_slot;
      next_even_hold = even_hold;
      next_even     = even_pixel_bus;
      next_odd      = odd_pixel_bus;
      next_de       = display_enable;
      next_hsync    = hsync;
      next_vsync    = vsync;
      next_ctl      = user_control_bits;
      next_offset_output_select_n_cnt = (offset_output_select_n_cnt != '0) ? offset_output_select_n_cnt - 1'b1 : offset_output_select_n_cnt;
      next_ock_cnt  = (ock_cnt != '0) ? ock_cnt - 1'b1 : ock_cnt;
      next_ock      = output_pixel_clock && (ock_cnt > 1);
      if (fire && pin[IN_PIXS] && !odd_slot && new_de)
         next_even_hold = pix;
      if (offset_output_select_n_cnt == 1)
         next_even = even_hold;
      if (present)
      begin
         next_de  = new_de;
         next_ock = 1'b1;
         next_ock_cnt = pin[IN_PIXS] ? TIMER_W'(PIXEL_CYCLES) : TIMER_W'(PIXEL_CYCLES / 2);
         if (new_de)
         begin
            if (!pin[IN_PIXS])
               next_even = pix;
            else
            begin
               next_odd = pix;
               // Quarter-period offset spreads the output switching current
               if (!pin[IN_OFFSET_OUTPUT_SELECT_N])
                  next_offset_output_select_n_cnt = TIMER_W'(STAGGER_CYCLES);
               else
                  next_even = even_hold;
            end
         end
         else
         begin
            next_hsync = cls[0][0];
            next_vsync = cls[0][1];
            next_ctl   = {cls[2][1], cls[2][0], cls[1][1]};
         end
      end
      next_data_oe = pin[IN_PD] && pin[IN_PDO];
      next_keep_oe = pin[IN_PD];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_vld           <= '0;
         for (int l = 0; l < LANES; l++)
            pend[l]         <= 10'h000;
         odd_slot           <= 1'b0;
         even_hold          <= 24'h0;
         offset_output_select_n_cnt           <= '0;
         ock_cnt            <= '0;
         even_pixel_bus     <= 24'h0;
         odd_pixel_bus      <= 24'h0;
         display_enable     <= 1'b0;
         hsync              <= 1'b0;
         vsync              <= 1'b0;
         user_control_bits  <= 3'h0;
         output_pixel_clock <= 1'b0;
         data_oe            <= 1'b0;
         keep_alive_oe      <= 1'b0;
      end
      else
      begin
         pend_vld           <= next_pend_vld;
         for (int l = 0; l < LANES; l++)
            pend[l]         <= next_pend[l];
         odd_slot           <= next_odd_slot;
         even_hold          <= next_even_hold;
         offset_output_select_n_cnt           <= next_offset_output_select_n_cnt;
         ock_cnt            <= next_ock_cnt;
         even_pixel_bus     <= next_even;
         odd_pixel_bus      <= next_odd;
         display_enable     <= next_de;
         hsync              <= next_hsync;
         vsync              <= next_vsync;
         user_control_bits  <= next_ctl;
         output_pixel_clock <= next_ock;
         data_oe            <= next_data_oe;
         keep_alive_oe      <= next_keep_oe;
      end
   end

   // --------------------------------------------------------------
   // Link activity detection
   // --------------------------------------------------------------
   logic             lclk_prev;
   logic             next_active;
   logic             seen_edge;
   logic             next_seen_edge;
   logic [CNT_W-1:0] per_cnt;
   logic [CNT_W-1:0] next_per_cnt;

   always_comb
   begin
      next_active    = link_active_flag;
      next_seen_edge = seen_edge;
      next_per_cnt   = per_cnt;
      // Powered-down core ignores the link entirely
      if (pin[IN_PD])
      begin
         if (de_toggle)
         begin
            if (seen_edge && per_cnt < CNT_W'(ACTIVE_WINDOW_PERIODS))
               next_active = 1'b1;
            next_seen_edge = 1'b1;
            next_per_cnt   = '0;
         end
         else if (pin[IN_LCLK] && !lclk_prev)
         begin
            if (per_cnt < CNT_W'(INACTIVE_PERIODS))
               next_per_cnt = per_cnt + 1'b1;
            if (per_cnt >= CNT_W'(INACTIVE_PERIODS - 1))
               next_active = 1'b0;
            if (per_cnt >= CNT_W'(ACTIVE_WINDOW_PERIODS - 1) && !link_active_flag)
               next_seen_edge = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lclk_prev        <= 1'b0;
         link_active_flag <= 1'b0;
         seen_edge        <= 1'b0;
         per_cnt          <= '0;
      end
      else
      begin
         lclk_prev        <= pin[IN_LCLK];
         link_active_flag <= next_active;
         seen_edge        <= next_seen_edge;
         per_cnt          <= next_per_cnt;
      end
   end

endmodule

// ---- testbench/tmr_rx_monitor.sv ----
// Port-level assertions for the pixel receiver
`timescale 1ns/1ps

module tmr_rx_monitor
   import tmr_pkg::*;
#(
   parameter int INACTIVE_PERIODS = INACTIVE_PERIODS_DEF
)(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hresp,
   input wire logic        hreadyout,
   input wire logic [23:0] even_pixel_bus,
   input wire logic [23:0] odd_pixel_bus,
   input wire logic        display_enable,
   input wire logic        hsync,
   input wire logic        vsync,
   input wire logic [3:1]  user_control_bits,
   input wire logic        output_pixel_clock,
   input wire logic        two_pixel_mode,
   input wire logic        offset_output_select_n,
   input wire logic        full_power_down_n,
   input wire logic        output_driver_off_n,
   input wire logic        data_oe,
   input wire logic        keep_alive_oe
);
   logic [7:0] since_rise;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ----------------
   // Age of the last output clock rise, saturating so long gaps stay quiet
   // ----------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         since_rise <= 8'hff;
      else if ($rose(output_pixel_clock))
         since_rise <= 8'h00;
      else if (since_rise != 8'hff)
         since_rise <= since_rise + 8'h01;
   end

   a_resp_okay: assert property (!hresp)
      else $error("error response seen");
   a_zero_wait: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state inserted");
   a_sync_in_blank:
      assert property ($changed({hsync, vsync, user_control_bits}) |-> !display_enable)
      else $error("syncs moved during active pixels");
   a_pixel_in_active:
      assert property ($changed(odd_pixel_bus) || ($changed(even_pixel_bus) && !two_pixel_mode)
         |-> display_enable) else $error("pixel bus moved during blanking");
   a_clock_one_pix:
      assert property ($rose(output_pixel_clock) && !two_pixel_mode
         |-> ##19 output_pixel_clock ##1 !output_pixel_clock) else $error("bad 1-pix clock");
   a_clock_two_pix:
      assert property ($rose(output_pixel_clock) && two_pixel_mode
         |-> ##39 output_pixel_clock ##1 !output_pixel_clock) else $error("bad 2-pix clock");
   a_stagger_delay:
      assert property ($changed(even_pixel_bus) && two_pixel_mode && !offset_output_select_n
         |-> since_rise == 8'd19) else $error("even bus not a quarter period late");
   a_full_power_down:
      assert property (!full_power_down_n [*8] |-> !data_oe && !keep_alive_oe)
      else $error("outputs driven in full power-down");
   a_driver_power_down:
      assert property ((!output_driver_off_n && full_power_down_n) [*8]
         |-> !data_oe && keep_alive_oe) else $error("wrong enables in driver power-down");
endmodule

bind tmr_receiver tmr_rx_monitor #(.INACTIVE_PERIODS(INACTIVE_PERIODS)) u_monitor (
   .hclk, .hresetn, .hresp, .hreadyout, .even_pixel_bus, .odd_pixel_bus, .display_enable,
   .hsync, .vsync, .user_control_bits, .output_pixel_clock, .two_pixel_mode,
   .offset_output_select_n, .full_power_down_n, .output_driver_off_n, .data_oe, .keep_alive_oe
);

// ---- testbench/tmr_tx_model.sv ----
// Behavioural three-lane serial transmitter at the far end of the link
`timescale 1ns/1ps

module tmr_tx_model
   import tmr_pkg::*;
#(
   parameter int SKEW = 12
)(
   input  wire logic hclk,
   output logic      blue_lane,
   output logic      green_lane,
   output logic      red_lane,
   output logic      link_clock
);
   localparam logic [9:0] TOKENS [4] = '{TOKEN_C00, TOKEN_C01, TOKEN_C10, TOKEN_C11};
   int          disp [3] = '{0, 0, 0};
   logic        red_raw = 1'b1;
   logic [15:0] red_dly = 16'hffff;

   // Red arrives late so the receiver must deskew it
   assign red_lane = red_dly[SKEW];
   always @(posedge hclk)
      red_dly <= {red_dly[14:0], red_raw};

   // Idle lanes sit high like terminated inputs; reference clock runs free
   initial
   begin
      blue_lane = 1'b1;
      green_lane = 1'b1;
      link_clock = 1'b0;
      forever #400 link_clock = ~link_clock;
   end

   function automatic logic [9:0] encode(input logic [7:0] d, inout int cnt);
      logic [8:0] qm;
      int         diff;
      logic       use_xnor;
      use_xnor = ($countones(d) > 4) || ($countones(d) == 4 && !d[0]);
      qm[0] = d[0];
      for (int i = 1; i < 8; i++)
         qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
      qm[8] = !use_xnor;
      diff = 2 * $countones(qm[7:0]) - 8;
      if (cnt == 0 || diff == 0)
      begin
         cnt += qm[8] ? diff : -diff;
         return {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
      end
      if ((cnt > 0) == (diff > 0))
      begin
         cnt += 2 * qm[8] - diff;
         return {1'b1, qm[8], ~qm[7:0]};
      end
      cnt += diff - 2 * !qm[8];
      return {1'b0, qm[8], qm[7:0]};
   endfunction

   // One symbol on all lanes, LSB first, four hclk per bit
   task automatic send(input logic de, input logic [23:0] pix, input logic [5:0] ctl);
      logic [9:0] sym [3];
      for (int l = 0; l < 3; l++)
      begin
         disp[l] = de ? disp[l] : 0;
         sym[l] = de ? encode(pix[8*l +: 8], disp[l]) : TOKENS[ctl[2*l +: 2]];
      end
      for (int b = 0; b < 10; b++)
      begin
         blue_lane <= sym[0][b];
         green_lane <= sym[1][b];
         red_raw <= sym[2][b];
         repeat (4) @(posedge hclk);
      end
   endtask
endmodule

// ---- testbench/tb_tmr_receiver.sv ----
// Self-checking bench for the pixel receiver
`timescale 1ns/1ps

module tb_tmr_receiver
   import tmr_pkg::*;
;
   localparam int          INACT = 1700;
   localparam logic [23:0] PIX [6] = '{24'h000000, 24'hffffff, 24'h123456, 24'ha5c30f,
                                       24'h808080, 24'h01fe7f};
   logic        hclk, hresetn = 1'b0, hwrite = 1'b0, chk_on = 1'b0, prev_de = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        full_power_down_n = 1'b1, output_driver_off_n = 1'b1;
   logic        two_pixel_mode = 1'b0, offset_output_select_n = 1'b1;
   logic        hreadyout, hresp, display_enable, hsync, vsync, output_pixel_clock;
   logic        link_active_flag, data_oe, keep_alive_oe, blue_lane, green_lane, red_lane;
   logic        link_clock;
   logic [23:0] even_pixel_bus, odd_pixel_bus, prev_pix = 24'h0;
   logic [3:1]  user_control_bits;
   logic [5:0]  prev_ctl = 6'h0;
   int          bad_count = 0, comparisons = 0;

   tmr_receiver #(.INACTIVE_PERIODS(INACT)) dut (
      .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .blue_lane, .green_lane, .red_lane,
      .link_clock, .full_power_down_n, .output_driver_off_n, .two_pixel_mode,
      .offset_output_select_n, .even_pixel_bus, .odd_pixel_bus, .display_enable, .hsync,
      .vsync, .user_control_bits, .output_pixel_clock, .link_active_flag, .data_oe,
      .keep_alive_oe
   );
   tmr_tx_model u_tx (.hclk, .blue_lane, .green_lane, .red_lane, .link_clock);

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // ----------------
   // Shared tasks
   // ----------------
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Single AHB word transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
   endtask

   // Sends one symbol; by its end the previous symbol is on the outputs
   task automatic sym(input logic de, input logic [23:0] pix, input logic [5:0] ctl);
      u_tx.send(de, pix, ctl);
      if (chk_on)
      begin
         check(32'(display_enable), 32'(prev_de));
         if (prev_de)
            check(32'(even_pixel_bus), 32'(prev_pix));
         else
            check(32'({hsync, vsync, user_control_bits}),
                  32'({prev_ctl[0], prev_ctl[1], prev_ctl[5], prev_ctl[4], prev_ctl[3]}));
      end
      prev_de = de;
      prev_pix = pix;
      prev_ctl = ctl;
   endtask

   task automatic warmup();
      chk_on = 1'b0;
      repeat (130) sym(1'b0, 24'h0, 6'h0);
   endtask

   // Hang guard, well above the expected run of about 28000 cycles
   initial
   begin
      repeat (70000) @(posedge hclk);
      bad_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done();
   end

   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, REG_STATUS, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 8'h0c, 32'hffff_ffff);
      bus(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, REG_CTRL, 32'h1);
      @(posedge hclk);
      bus(1'b0, REG_CTRL, 32'h0);
      check(rd, CTRL_RST);
      warmup();
      chk_on = 1'b1;
      for (int i = 0; i < 63; i++)
         sym(1'b0, 24'h0, 6'(i));
      // Status read rides along with a symbol so the lanes see no gap
      fork
         sym(1'b0, 24'h0, 6'h3f);
         bus(1'b0, REG_STATUS, 32'h0);
      join
      check(rd, 32'h70);
      for (int i = 0; i < 6; i++)
         sym(1'b1, PIX[i], 6'h0);
      repeat (2) sym(1'b0, 24'h0, 6'h2a);
      check(32'(link_active_flag), 32'h1);
      repeat (300) sym(1'b0, 24'h0, 6'h0);
      check(32'(link_active_flag), 32'h1);
      repeat (60) sym(1'b0, 24'h0, 6'h0);
      check(32'(link_active_flag), 32'h0);
      repeat (2) sym(1'b1, 24'h00ff00, 6'h0);
      check(32'(link_active_flag), 32'h0);
      repeat (2) sym(1'b0, 24'h0, 6'h0);
      check(32'(link_active_flag), 32'h1);
      output_driver_off_n <= 1'b0;
      repeat (10) @(posedge hclk);
      check(32'({data_oe, keep_alive_oe, link_active_flag}), 32'h3);
      output_driver_off_n <= 1'b1;
      full_power_down_n <= 1'b0;
      repeat (10) @(posedge hclk);
      check(32'({data_oe, keep_alive_oe}), 32'h0);
      two_pixel_mode <= 1'b1;
      offset_output_select_n <= 1'b0;
      repeat (10) @(posedge hclk);
      full_power_down_n <= 1'b1;
      warmup();
      repeat (8) sym(1'b1, 24'h3c5a96, 6'h0);
      check(32'(odd_pixel_bus), 32'h3c5a96);
      check(32'(even_pixel_bus), 32'h3c5a96);
      test_done();
   end
endmodule
